// ---- rtl/dil_pkg.sv ----
// constants and types for the deinterlacer control register bank
package dil_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register locations
  localparam logic [4:0] LOC_STD_MODE = 5'h00;
  localparam logic [4:0] LOC_PROC_CTRL = 5'h01;
  localparam logic [4:0] LOC_USER_LAST = 5'h0E;
  localparam logic [4:0] LOC_AUTO_FIRST = 5'h0F;

  // location 0 fields
  localparam int STD_LSB = 0;
  localparam int STD_W = 5;
  localparam int MODE_LSB = 5;
  localparam int MODE_W = 3;
  localparam int SEQ_LSB = 8;
  localparam int SEQ_W = 4;
  localparam int FREEZE_HIT_BIT = 12;
  localparam int LOCK_BIT = 13;

  // location 1 fields
  localparam int FF_SEL_LSB = 0;
  localparam int FF_SEL_W = 2;
  localparam int FF_MAN_EN_BIT = 2;
  localparam int MD_SEL_LSB = 4;
  localparam int MD_SEL_W = 2;
  localparam int CAD_SRC_BIT = 6;
  localparam int CC_BLANK_BIT = 7;
  localparam int CLIP_LSB = 8;
  localparam int CLIP_W = 3;
  localparam int CROP_BIT = 11;
  localparam int EXT_SYNC_BIT = 12;
  localparam int F_POL_BIT = 13;
  localparam int V_POL_BIT = 14;
  localparam int H_POL_BIT = 15;

  // reset values
  localparam logic [4:0] RST_STD = 5'h00;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [15:0] RST_PROC_CTRL = 16'hE015;

  typedef enum logic [2:0] {
    DIL_MODE_I2P = 3'h0,
    DIL_MODE_MERGE = 3'h1,
    DIL_MODE_FILM = 3'h2,
    DIL_MODE_FILM_PSF = 3'h3,
    DIL_MODE_BYPASS = 3'h7
  } dil_proc_mode_t;

  typedef enum logic [1:0] {
    DIL_FF_MANUAL = 2'h0,
    DIL_FF_AUTO = 2'h1,
    DIL_FF_OFF = 2'h2,
    DIL_FF_RSVD = 2'h3
  } dil_ff_sel_t;

  typedef enum logic [1:0] {
    DIL_MD_OFF = 2'h0,
    DIL_MD_AUTO = 2'h1
  } dil_md_sel_t;

  typedef enum logic [2:0] {
    DIL_CL_12B = 3'h0,
    DIL_CL_10B_FULL = 3'h1,
    DIL_CL_10B_4_1019 = 3'h2,
    DIL_CL_10B_STUDIO = 3'h3,
    DIL_CL_RSVD = 3'h4,
    DIL_CL_8B_FULL = 3'h5,
    DIL_CL_8B_1_254 = 3'h6,
    DIL_CL_8B_STUDIO = 3'h7
  } dil_clip_t;

endpackage

// ---- rtl/dil_ctrl_regs.sv ----
// control registers at locations 0 and 1 of the deinterlacer host port
`timescale 1ns/1ps

module dil_ctrl_regs
  import dil_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [DATA_W-1:0] i_host_wdata,
  input wire logic [SEQ_W-1:0] i_detect_seq,
  input wire logic i_detect_freeze,
  input wire logic i_detect_lock,
  input wire logic [SEQ_W-1:0] i_external_cadence_pins,
  input wire logic i_field_pin,
  input wire logic i_vsync_pin,
  input wire logic i_hsync_pin,
  output logic [DATA_W-1:0] o_host_rdata,
  output logic o_host_rvalid,
  output logic o_auto_reload,
  output logic o_auto_hit,
  output logic [STD_W-1:0] o_video_standard_select,
  output logic [MODE_W-1:0] o_proc_mode,
  output logic [SEQ_W-1:0] o_cadence_seq,
  output logic o_freeze_comp_on,
  output logic o_motion_comp_on,
  output logic o_caption_blank_enable,
  output logic [CLIP_W-1:0] o_output_clip_round_select,
  output logic o_output_crop_enable,
  output logic o_external_sync_select,
  output logic o_field_even,
  output logic o_vblank,
  output logic o_hblank
);

  ////////////////////////////////////////////////////////////////////////////
  // polarity helper: normal sense passes, cleared bit inverts
  function automatic logic apply_pol(input logic pin, input logic normal);
    apply_pol = normal ? pin : ~pin;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // write strobe aimed at one location; shared by both writable words
  function automatic logic host_wr_to(input logic wr,
    input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] loc);
    host_wr_to = wr && (addr == loc);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // freeze compensation from handling select and manual enable;
  // reserved code treated as disabled, the safe choice
  function automatic logic freeze_on(input logic [1:0] sel,
    input logic man_en);
    case (sel)
      DIL_FF_MANUAL: freeze_on = man_en;
      DIL_FF_AUTO: freeze_on = 1'b1;
      default: freeze_on = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // motion compensation only on the automatic code; reserved codes off
  function automatic logic motion_on(input logic [1:0] sel);
    motion_on = (sel == DIL_MD_AUTO);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // location 0 read image: writable fields low, live status above;
  // bits 15:14 hold nothing and read as zero
  function automatic logic [DATA_W-1:0] loc0_word(
    input logic [STD_W-1:0] vid_f, input logic [MODE_W-1:0] mode_f,
    input logic [SEQ_W-1:0] seq_f, input logic frz_f, input logic lck_f);
    loc0_word = 16'h0000;
    loc0_word[STD_LSB +: STD_W] = vid_f;
    loc0_word[MODE_LSB +: MODE_W] = mode_f;
    loc0_word[SEQ_LSB +: SEQ_W] = seq_f;
    loc0_word[FREEZE_HIT_BIT] = frz_f;
    loc0_word[LOCK_BIT] = lck_f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by second stage
  logic [SEQ_W-1:0] cad_meta;
  logic [SEQ_W-1:0] cad_sync;
  logic [2:0] sync_meta;
  logic [2:0] sync_pins;
  logic [SEQ_W-1:0] next_cad_meta;
  logic [SEQ_W-1:0] next_cad_sync;
  logic [2:0] next_sync_meta;
  logic [2:0] next_sync_pins;

  always_comb
  begin
    next_cad_meta = i_external_cadence_pins;
    next_cad_sync = cad_meta;
    next_sync_meta = {i_field_pin, i_vsync_pin, i_hsync_pin};
    next_sync_pins = sync_meta;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cad_meta <= 4'h0;
      cad_sync <= 4'h0;
      sync_meta <= 3'h0;
      sync_pins <= 3'h0;
    end
    else
    begin
      cad_meta <= next_cad_meta;
      cad_sync <= next_cad_sync;
      sync_meta <= next_sync_meta;
      sync_pins <= next_sync_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host writable fields
  logic [STD_W-1:0] std_sel;
  logic [MODE_W-1:0] mode_sel;
  logic [DATA_W-1:0] proc_ctrl;
  logic [STD_W-1:0] next_std_sel;
  logic [MODE_W-1:0] next_mode_sel;
  logic [DATA_W-1:0] next_proc_ctrl;
  logic wr_loc0;
  logic wr_loc1;

  always_comb
  begin
    wr_loc0 = host_wr_to(i_host_wr, i_host_addr, LOC_STD_MODE);
    wr_loc1 = host_wr_to(i_host_wr, i_host_addr, LOC_PROC_CTRL);
    next_std_sel = std_sel;
    next_mode_sel = mode_sel;
    next_proc_ctrl = proc_ctrl;
    if (wr_loc0)
    begin
      // status bits 13:8 of the write data are dropped here
      next_std_sel = i_host_wdata[STD_LSB +: STD_W];
      next_mode_sel = i_host_wdata[MODE_LSB +: MODE_W];
    end
    if (wr_loc1)
    begin
      next_proc_ctrl = i_host_wdata;
      // bit 3 holds nothing and reads as zero
      next_proc_ctrl[3] = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      std_sel <= RST_STD;
      mode_sel <= RST_MODE;
      proc_ctrl <= RST_PROC_CTRL;
    end
    else
    begin
      std_sel <= next_std_sel;
      mode_sel <= next_mode_sel;
      proc_ctrl <= next_proc_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read-only status, refreshed every cycle by the detectors
  logic [SEQ_W-1:0] stat_seq;
  logic stat_freeze;
  logic stat_lock;
  logic [SEQ_W-1:0] next_stat_seq;
  logic next_stat_freeze;
  logic next_stat_lock;

  always_comb
  begin
    next_stat_seq = i_detect_seq;
    next_stat_freeze = i_detect_freeze;
    next_stat_lock = i_detect_lock;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      stat_seq <= 4'h0;
      stat_freeze <= 1'b0;
      stat_lock <= 1'b0;
    end
    else
    begin
      stat_seq <= next_stat_seq;
      stat_freeze <= next_stat_freeze;
      stat_lock <= next_stat_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read port and auto-class handshake
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_reload;
  logic next_auto_hit;

  always_comb
  begin
    next_rdata = 16'h0000;
    next_rvalid = i_host_rd;
    // standard or mode change asks the auto class to reload
    next_reload = wr_loc0;
    // host write into auto class is flagged so its value is kept
    next_auto_hit = i_host_wr && (i_host_addr >= LOC_AUTO_FIRST);
    if (i_host_rd)
    begin
      case (i_host_addr)
        LOC_STD_MODE:
        begin
          next_rdata = loc0_word(std_sel, mode_sel, stat_seq,
            stat_freeze, stat_lock);
        end
        LOC_PROC_CTRL:
        begin
          next_rdata = proc_ctrl;
        end
        default:
        begin
          // other locations live outside this bank
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_host_rdata <= 16'h0000;
      o_host_rvalid <= 1'b0;
      o_auto_reload <= 1'b0;
      o_auto_hit <= 1'b0;
    end
    else
    begin
      o_host_rdata <= next_rdata;
      o_host_rvalid <= next_rvalid;
      o_auto_reload <= next_reload;
      o_auto_hit <= next_auto_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls toward the datapath
  logic [STD_W-1:0] next_o_std;
  logic [MODE_W-1:0] next_o_mode;
  logic [SEQ_W-1:0] next_o_cad;
  logic next_o_ff;
  logic next_o_md;
  logic next_o_cc;
  logic [CLIP_W-1:0] next_o_clip;
  logic next_o_crop;
  logic next_o_ext;
  logic next_o_field;
  logic next_o_vb;
  logic next_o_hb;
  logic [1:0] ff_sel;
  logic [1:0] md_sel;

  always_comb
  begin
    ff_sel = proc_ctrl[FF_SEL_LSB +: FF_SEL_W];
    md_sel = proc_ctrl[MD_SEL_LSB +: MD_SEL_W];
    next_o_std = std_sel;
    next_o_mode = mode_sel;
    next_o_cad = proc_ctrl[CAD_SRC_BIT] ? cad_sync : i_detect_seq;
    next_o_ff = freeze_on(ff_sel, proc_ctrl[FF_MAN_EN_BIT]);
    next_o_md = motion_on(md_sel);
    next_o_cc = proc_ctrl[CC_BLANK_BIT];
    // code 100 is passed on as is; datapath decides
    next_o_clip = proc_ctrl[CLIP_LSB +: CLIP_W];
    next_o_crop = proc_ctrl[CROP_BIT];
    next_o_ext = proc_ctrl[EXT_SYNC_BIT];
    next_o_field = apply_pol(sync_pins[2], proc_ctrl[F_POL_BIT]);
    next_o_vb = apply_pol(sync_pins[1], proc_ctrl[V_POL_BIT]);
    next_o_hb = apply_pol(sync_pins[0], proc_ctrl[H_POL_BIT]);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_video_standard_select <= RST_STD;
      o_proc_mode <= RST_MODE;
      o_cadence_seq <= 4'h0;
      o_freeze_comp_on <= 1'b0;
      o_motion_comp_on <= 1'b0;
      o_caption_blank_enable <= 1'b0;
      o_output_clip_round_select <= 3'h0;
      o_output_crop_enable <= 1'b0;
      o_external_sync_select <= 1'b0;
      o_field_even <= 1'b0;
      o_vblank <= 1'b0;
      o_hblank <= 1'b0;
    end
    else
    begin
      o_video_standard_select <= next_o_std;
      o_proc_mode <= next_o_mode;
      o_cadence_seq <= next_o_cad;
      o_freeze_comp_on <= next_o_ff;
      o_motion_comp_on <= next_o_md;
      o_caption_blank_enable <= next_o_cc;
      o_output_clip_round_select <= next_o_clip;
      o_output_crop_enable <= next_o_crop;
      o_external_sync_select <= next_o_ext;
      o_field_even <= next_o_field;
      o_vblank <= next_o_vb;
      o_hblank <= next_o_hb;
    end
  end

endmodule

// ---- tb/dil_ctrl_regs_sva.sv ----
// checker for the host port and decoded outputs of the control registers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module dil_ctrl_regs_chk
  import dil_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [DATA_W-1:0] i_host_wdata,
  input wire logic [SEQ_W-1:0] i_detect_seq,
  input wire logic i_detect_freeze,
  input wire logic i_detect_lock,
  input wire logic [DATA_W-1:0] o_host_rdata,
  input wire logic o_host_rvalid,
  input wire logic o_auto_reload,
  input wire logic o_auto_hit,
  input wire logic [STD_W-1:0] o_video_standard_select,
  input wire logic [MODE_W-1:0] o_proc_mode,
  input wire logic o_freeze_comp_on,
  input wire logic o_motion_comp_on,
  input wire logic o_caption_blank_enable,
  input wire logic [CLIP_W-1:0] o_output_clip_round_select,
  input wire logic o_output_crop_enable,
  input wire logic o_external_sync_select
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // write data two edges back, lined up with the decoded outputs
  logic [DATA_W-1:0] wd1;
  logic [DATA_W-1:0] wd2;
  logic wr0;
  logic wr1;
  always_ff @(posedge i_clk_sys)
  begin
    wd1 <= i_host_wdata;
    wd2 <= wd1;
  end
  assign wr0 = i_host_wr && (i_host_addr == LOC_STD_MODE);
  assign wr1 = i_host_wr && (i_host_addr == LOC_PROC_CTRL);
  ////////////////////////////////////////////////////////////////////////
  property p_rvalid;
    i_host_rd |=> o_host_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  property p_rdata_idle;
    !o_host_rvalid |-> o_host_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("idle rdata");
  // status bits read back the detector inputs of two edges earlier, unless reset was sampled high
  property p_status;
    i_host_rd && i_host_addr == LOC_STD_MODE && !$past(i_reset) |=>
      o_host_rdata[15:8] == {2'b00, $past(i_detect_lock, 2),
      $past(i_detect_freeze, 2), $past(i_detect_seq, 2)};
  endproperty
  a_status: assert property (p_status) else $error("status bits");
  property p_std;
    wr0 |=> ##1 {o_proc_mode, o_video_standard_select} == wd2[7:0];
  endproperty
  a_std: assert property (p_std) else $error("standard or mode");
  property p_freeze;
    wr1 |=> ##1 o_freeze_comp_on ==
      (wd2[1:0] == 2'h1 || (wd2[1:0] == 2'h0 && wd2[2]));
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze enable");
  property p_motion;
    wr1 |=> ##1 o_motion_comp_on == (wd2[5:4] == 2'h1);
  endproperty
  a_motion: assert property (p_motion) else $error("motion enable");
  property p_ctrl;
    wr1 |=> ##1 {o_external_sync_select, o_output_crop_enable,
      o_output_clip_round_select, o_caption_blank_enable} == wd2[12:7];
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control copies");
  property p_hit;
    i_host_wr |=> o_auto_hit == ($past(i_host_addr) >= LOC_AUTO_FIRST);
  endproperty
  a_hit: assert property (p_hit) else $error("auto location hit");
  property p_reload;
    wr0 |=> o_auto_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload pulse");
  c_rd_status: cover property (i_host_rd && i_host_addr == LOC_STD_MODE);
  c_hit: cover property (o_auto_hit);
  c_manual: cover property (wr1 && i_host_wdata[1:0] == 2'h0);
endmodule

bind dil_ctrl_regs dil_ctrl_regs_chk i_dil_ctrl_regs_chk (.*);

// ---- tb/dil_host_model.sv ----
// host processor model driving the parallel register port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module dil_host_model
  import dil_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [DATA_W-1:0] i_host_rdata,
  input wire logic i_host_rvalid,
  output logic [ADDR_W-1:0] o_host_addr,
  output logic o_host_wr,
  output logic o_host_rd,
  output logic [DATA_W-1:0] o_host_wdata
);
  initial
  begin
    o_host_addr = 5'h00;
    o_host_wr = 1'b0;
    o_host_rd = 1'b0;
    o_host_wdata = 16'h0000;
  end
  // one strobe cycle, then the answer is taken one edge later
  task automatic access(input logic wr, input logic [4:0] a,
    input logic [15:0] d, output logic [15:0] q, output logic v);
    @(negedge i_clk_sys);
    o_host_addr = a;
    o_host_wdata = d;
    o_host_wr = wr;
    o_host_rd = !wr;
    @(negedge i_clk_sys);
    // the answer stands only in the cycle after the strobe edge
    q = i_host_rdata;
    v = i_host_rvalid;
    o_host_wr = 1'b0;
    o_host_rd = 1'b0;
    // released lines flip so a stale value never passes for fresh data
    o_host_addr = ~a;
    o_host_wdata = ~d;
    // one more edge so decoded outputs have settled on return
    @(negedge i_clk_sys);
  endtask
endmodule

// ---- tb/dil_ctrl_regs_test.sv ----
// self-checking bench for the deinterlacer control registers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module dil_ctrl_regs_test;
  import dil_pkg::*;
  logic clk, rst, wr, rd, frz, lck, fp, vp, hp, rv, reload, hit, ffc, mdc;
  logic cc, crop, ext, feven, vb, hb;
  logic [4:0] addr, vid_sel;
  logic [15:0] wd, rdat;
  logic [3:0] seq, xp, cad;
  logic [2:0] mode, clip;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_reload = 0;
  int n_hit = 0;
  dil_ctrl_regs i_dil_ctrl_regs (.i_clk_sys(clk), .i_reset(rst),
    .i_host_addr(addr), .i_host_wr(wr), .i_host_rd(rd), .i_host_wdata(wd),
    .i_detect_seq(seq), .i_detect_freeze(frz), .i_detect_lock(lck),
    .i_external_cadence_pins(xp), .i_field_pin(fp), .i_vsync_pin(vp),
    .i_hsync_pin(hp), .o_host_rdata(rdat), .o_host_rvalid(rv),
    .o_auto_reload(reload), .o_auto_hit(hit),
    .o_video_standard_select(vid_sel), .o_proc_mode(mode),
    .o_cadence_seq(cad), .o_freeze_comp_on(ffc), .o_motion_comp_on(mdc),
    .o_caption_blank_enable(cc), .o_output_clip_round_select(clip),
    .o_output_crop_enable(crop), .o_external_sync_select(ext),
    .o_field_even(feven), .o_vblank(vb), .o_hblank(hb));
  dil_host_model i_dil_host_model (.i_clk_sys(clk), .i_host_rdata(rdat),
    .i_host_rvalid(rv), .o_host_addr(addr), .o_host_wr(wr),
    .o_host_rd(rd), .o_host_wdata(wd));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic v;
    i_dil_host_model.access(1'b1, a, d, q, v);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic v;
    i_dil_host_model.access(1'b0, a, 16'h0000, q, v);
    chk(v, 1'b1);
    chk(q, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(LOC_STD_MODE, 16'h0000);
    rdc(LOC_PROC_CTRL, 16'hE015);
    chk({ffc, mdc}, 2'b11);
  endtask
  task automatic t_loc0;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int r0;
    seq = 4'hA;
    frz = 1'b1;
    lck = 1'b1;
    wrt(LOC_STD_MODE, 16'hFFFF);
    rdc(LOC_STD_MODE, 16'h3AFF);
    foreach (codes[i])
    begin
      r0 = n_reload;
      wrt(LOC_STD_MODE, {8'h00, codes[i], 5'h15});
      chk({mode, vid_sel}, {codes[i], 5'h15});
      chk(16'(n_reload - r0), 16'h0001);
    end
    seq = 4'h5;
    frz = 1'b0;
    lck = 1'b0;
    rdc(LOC_STD_MODE, 16'h05F5);
  endtask
  task automatic t_loc1;
    logic [15:0] w;
    for (int k = 0; k < 16; k++)
    begin
      w = {3'b111, k[0], k[1], k[2:0], k[3], 1'b0, k[1:0], 1'b0, k[3],
        k[1:0]};
      wrt(LOC_PROC_CTRL, w);
      chk(ffc, k[1:0] == 2'h1 || (k[1:0] == 2'h0 && k[3]));
      chk(mdc, k[1:0] == 2'h1);
      chk({ext, crop, clip, cc}, w[12:7]);
      rdc(LOC_PROC_CTRL, w);
    end
  endtask
  task automatic t_pins;
    fp = 1'b1;
    vp = 1'b1;
    hp = 1'b0;
    xp = 4'h9;
    wrt(LOC_PROC_CTRL, 16'h0040);
    repeat (4) @(negedge clk);
    chk({feven, vb, hb, cad}, {3'b001, 4'h9});
    wrt(LOC_PROC_CTRL, 16'hE000);
    repeat (4) @(negedge clk);
    chk({feven, vb, hb, cad}, {3'b110, seq});
  endtask
  task automatic t_other;
    int h0;
    wrt(5'h02, 16'h1234);
    rdc(5'h02, 16'h0000);
    h0 = n_hit;
    wrt(LOC_USER_LAST, 16'h00FF);
    chk(16'(n_hit - h0), 16'h0000);
    wrt(LOC_AUTO_FIRST, 16'h00FF);
    chk(16'(n_hit - h0), 16'h0001);
    wrt(5'h1F, 16'hFFFF);
    chk(16'(n_hit - h0), 16'h0002);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // one-cycle pulses are counted at the falling edge, where they settle
  always @(negedge clk)
  begin
    if (reload === 1'b1)
      n_reload++;
    if (hit === 1'b1)
      n_hit++;
  end
  // the whole run is about 160 cycles, the ceiling of 3000 leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1;
    {seq, frz, lck, xp, fp, vp, hp} = 13'h0000;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_loc0();
    t_loc1();
    t_pins();
    t_other();
    wrap_up();
  end
endmodule
